// [verilog/rssd_pkg.sv]
// Package of opcodes, widths and constants for the rotate, subtract and skip datapath
package rssd_pkg;
  localparam int DATA_W = 8;
  localparam int BITSEL_W = 3;
  localparam logic [7:0] ALL_ONES = 8'h_ff;
  localparam logic [7:0] ONE_BYTE = 8'h_01;
  localparam logic [7:0] ZERO_BYTE = 8'h_00;
  localparam logic [3:0] ZERO_NIB = 4'h_0;
  localparam int MSB = 7;
  localparam int LSB = 0;
  localparam int NIB_MSB = 3;
  // Instruction cycles taken by a skip-capable instruction
  localparam int SKIP_CYCLES = 2;
  localparam logic [1:0] SKIP_HOLD = 2'(SKIP_CYCLES - 1);
  localparam logic RESET_CARRY = 1'b0;
  localparam logic RESET_FLAG = 1'b0;

  typedef enum logic [3:0] {
    RSSD_OP_NONE,
    RSSD_OP_ROTATE_LEFT_VIA_CARRY,
    RSSD_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK,
    RSSD_OP_ROTATE_RIGHT_PLAIN,
    RSSD_OP_ROTATE_RIGHT_PLAIN_TO_WORK,
    RSSD_OP_ROTATE_RIGHT_VIA_CARRY,
    RSSD_OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK,
    RSSD_OP_SUBTRACT_WITH_BORROW,
    RSSD_OP_SUBTRACT_WITH_BORROW_TO_MEMORY,
    RSSD_OP_DECREMENT_SKIP_ZERO,
    RSSD_OP_DECREMENT_SKIP_ZERO_TO_WORK,
    RSSD_OP_FILL_ONES,
    RSSD_OP_SET_BIT
  } rssd_op_t;

  typedef enum logic {
    RSSD_ST_RUN,
    RSSD_ST_DUMMY
  } rssd_state_t;
endpackage : rssd_pkg

// [verilog/rssd_subtractor.sv]
// Combinational 8-bit subtract-with-borrow and its flags
`timescale 1ns/1ns
module rssd_subtractor
  import rssd_pkg::*;
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carryIn,
  output logic      [7:0] diff,
  output logic            carryOut,
  output logic            halfOut,
  output logic            wrapOut,
  output logic            zeroOut
);
  logic [8:0] wide;
  logic [4:0] lowNib;

  always_comb begin
    // Adding the inverse keeps carry in the no-borrow polarity directly
    wide     = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h_00, carryIn};
    lowNib   = {1'b0, minuend[NIB_MSB:0]} + {1'b0, ~subtrahend[NIB_MSB:0]}
               + {4'h_0, carryIn};
    diff     = wide[7:0];
    carryOut = wide[8];
    halfOut  = lowNib[4];
    wrapOut  = (minuend[MSB] ^ subtrahend[MSB]) & (minuend[MSB] ^ wide[MSB]);
    zeroOut  = (wide[7:0] == ZERO_BYTE);
  end
endmodule : rssd_subtractor

// [verilog/rssd_datapath.sv]
// Execution datapath for rotates, subtract-with-borrow, decrement-skip, fill and bit set
// Notes on behaviour
// - Rotate left via carry: memory gets byte<<1 with old carry in bit 0; carry=bit 7.
// - Work variant of left rotate via carry: result to work register, carry from bit 7.
// - Plain rotate right: bit 0 moves to bit 7, result to memory, no flags.
// - Work variant of plain rotate right: result to work register, no flags.
// - Rotate right via carry: old carry into bit 7, carry from bit 0, to memory.
// - Work variant of right rotate via carry: result to work register, carry from bit 0.
// - Subtract with borrow: work minus memory minus inverted carry into work.
// - Memory variant of subtract with borrow writes the difference to memory.
// - Carry cleared on negative difference, set when zero or positive.
// - Decrement skip zero: memory minus one written back, skip when zero, no flags.
// - Work variant of decrement skip: result to work register, skip when zero.
// - Decrement skip instructions take two cycles through an inserted dummy cycle.
// - Fill writes all ones to memory and changes no flag.
// - Bit set forces the selected memory bit high, keeps others, no flags.
`timescale 1ns/1ns
module rssd_datapath
  import rssd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       opValid,
  input  wire rssd_op_t   opCode,
  input  wire logic [7:0] memData,
  input  wire logic [2:0] bitSel,
  output logic            opReady,
  output logic [7:0]      workReg,
  output logic            carryFlag,
  output logic            signedWrapFlag,
  output logic            halfBorrowFlag,
  output logic            zeroFlag,
  output logic            memWrite,
  output logic [7:0]      memWriteData,
  output logic            skipNext,
  output logic            dummyCycle
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  workReg_q;
  logic        carry_q;
  logic        wrap_q;
  logic        half_q;
  logic        zero_q;
  logic        memWrite_q;
  logic [7:0]  memData_q;
  logic        skip_q;
  logic        dummy_q;
  rssd_state_t state_q;

  logic [7:0]  subDiff;
  logic        subCarry;
  logic        subHalf;
  logic        subWrap;
  logic        subZero;
  logic [7:0]  decVal;
  logic [7:0]  bitMask;
  logic        accept;
  logic        isSub;
  logic        isDec;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic
  rssd_subtractor uSub (
    .minuend    (workReg_q),
    .subtrahend (memData),
    .carryIn    (carry_q),
    .diff       (subDiff),
    .carryOut   (subCarry),
    .halfOut    (subHalf),
    .wrapOut    (subWrap),
    .zeroOut    (subZero)
  );

  // Modulo 256: zero decrements to all ones, which never skips
  assign decVal  = memData - ONE_BYTE;
  assign bitMask = ONE_BYTE << bitSel;
  // New operations are refused during the dummy cycle
  assign accept  = opValid && (state_q == RSSD_ST_RUN);
  assign isSub   = (opCode == RSSD_OP_SUBTRACT_WITH_BORROW)
                || (opCode == RSSD_OP_SUBTRACT_WITH_BORROW_TO_MEMORY);
  assign isDec   = (opCode == RSSD_OP_DECREMENT_SKIP_ZERO)
                || (opCode == RSSD_OP_DECREMENT_SKIP_ZERO_TO_WORK);

  ////////////////////////////////////////////////////////////////////////////
  // Working register
  always_ff @(posedge clk) begin
    if (srst) begin
      workReg_q <= ZERO_BYTE;
    end else if (accept) begin
      case (opCode)
        RSSD_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK:  workReg_q <= {memData[6:0], carry_q};
        RSSD_OP_ROTATE_RIGHT_PLAIN_TO_WORK:     workReg_q <= {memData[LSB], memData[7:1]};
        RSSD_OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK: workReg_q <= {carry_q, memData[7:1]};
        RSSD_OP_SUBTRACT_WITH_BORROW:           workReg_q <= subDiff;
        RSSD_OP_DECREMENT_SKIP_ZERO_TO_WORK:    workReg_q <= decVal;
        default:                                workReg_q <= workReg_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry flag
  always_ff @(posedge clk) begin
    if (srst) begin
      carry_q <= RESET_CARRY;
    end else if (accept) begin
      case (opCode)
        RSSD_OP_ROTATE_LEFT_VIA_CARRY,
        RSSD_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK:  carry_q <= memData[MSB];
        RSSD_OP_ROTATE_RIGHT_VIA_CARRY,
        RSSD_OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK: carry_q <= memData[LSB];
        RSSD_OP_SUBTRACT_WITH_BORROW,
        RSSD_OP_SUBTRACT_WITH_BORROW_TO_MEMORY: carry_q <= subCarry;
        default:                                carry_q <= carry_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic flags, touched only by subtraction
  always_ff @(posedge clk) begin
    if (srst) begin
      wrap_q <= RESET_FLAG;
      half_q <= RESET_FLAG;
      zero_q <= RESET_FLAG;
    end else if (accept && isSub) begin
      wrap_q <= subWrap;
      half_q <= subHalf;
      zero_q <= subZero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory write-back
  always_ff @(posedge clk) begin
    if (srst) begin
      memWrite_q <= 1'b0;
      memData_q  <= ZERO_BYTE;
    end else begin
      memWrite_q <= 1'b0;
      if (accept) begin
        case (opCode)
          RSSD_OP_ROTATE_LEFT_VIA_CARRY: begin
            memWrite_q <= 1'b1;
            memData_q  <= {memData[6:0], carry_q};
          end
          RSSD_OP_ROTATE_RIGHT_PLAIN: begin
            memWrite_q <= 1'b1;
            memData_q  <= {memData[LSB], memData[7:1]};
          end
          RSSD_OP_ROTATE_RIGHT_VIA_CARRY: begin
            memWrite_q <= 1'b1;
            memData_q  <= {carry_q, memData[7:1]};
          end
          RSSD_OP_SUBTRACT_WITH_BORROW_TO_MEMORY: begin
            memWrite_q <= 1'b1;
            memData_q  <= subDiff;
          end
          RSSD_OP_DECREMENT_SKIP_ZERO: begin
            memWrite_q <= 1'b1;
            memData_q  <= decVal;
          end
          RSSD_OP_FILL_ONES: begin
            memWrite_q <= 1'b1;
            memData_q  <= ALL_ONES;
          end
          RSSD_OP_SET_BIT: begin
            memWrite_q <= 1'b1;
            memData_q  <= memData | bitMask;
          end
          default: begin
            memWrite_q <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip and dummy cycle sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= RSSD_ST_RUN;
      skip_q  <= 1'b0;
      dummy_q <= 1'b0;
    end else begin
      skip_q <= 1'b0;
      case (state_q)
        RSSD_ST_RUN: begin
          dummy_q <= 1'b0;
          if (accept && isDec) begin
            skip_q  <= (decVal == ZERO_BYTE);
            state_q <= RSSD_ST_DUMMY;
            dummy_q <= 1'b1;
          end
        end
        RSSD_ST_DUMMY: begin
          // One dummy cycle covers the fetch of the next instruction
          state_q <= RSSD_ST_RUN;
          dummy_q <= 1'b0;
        end
        default: begin
          state_q <= RSSD_ST_RUN;
        end
      endcase
    end
  end

  // Ready registered so it stays low through the dummy cycle
  logic ready_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= !(accept && isDec);
    end
  end

  assign opReady        = ready_q;
  assign workReg        = workReg_q;
  assign carryFlag      = carry_q;
  assign signedWrapFlag = wrap_q;
  assign halfBorrowFlag = half_q;
  assign zeroFlag       = zero_q;
  assign memWrite       = memWrite_q;
  assign memWriteData   = memData_q;
  assign skipNext       = skip_q;
  assign dummyCycle     = dummy_q;
endmodule : rssd_datapath

// [verif/rssd_datapath_monitor.sv]
// Port checker for the datapath
`timescale 1ns/1ns
module rssd_datapath_monitor
  import rssd_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       opValid,
  input wire rssd_op_t   opCode,
  input wire logic [7:0] memData,
  input wire logic [2:0] bitSel,
  input wire logic       opReady,
  input wire logic [7:0] workReg,
  input wire logic       carryFlag,
  input wire logic       signedWrapFlag,
  input wire logic       halfBorrowFlag,
  input wire logic       zeroFlag,
  input wire logic       memWrite,
  input wire logic [7:0] memWriteData,
  input wire logic       skipNext,
  input wire logic       dummyCycle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic       take;
  logic       noBorrow;
  logic [7:0] rrByte;
  logic [7:0] setByte;
  assign take = opValid && opReady;
  // Nine bits so memData plus the borrow cannot wrap past ff in the compare
  assign noBorrow = {1'b0, workReg} >= ({1'b0, memData} + {8'h00, !carryFlag});
  assign rrByte = {memData[0], memData[7:1]};
  assign setByte = memData | (8'h01 << bitSel);
  rot_left_a: assert property (take && opCode == RSSD_OP_ROTATE_LEFT_VIA_CARRY |=>
    memWrite && {carryFlag, memWriteData} == {$past(memData), $past(carryFlag)})
    else $error("left rotate via carry wrong");
  rot_right_a: assert property (take && opCode == RSSD_OP_ROTATE_RIGHT_PLAIN |=>
    memWriteData == $past(rrByte) && $stable(carryFlag)) else $error("plain rotate wrong");
  rrc_work_a: assert property (take && opCode == RSSD_OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK
    |=> !memWrite && {workReg, carryFlag} == {$past(carryFlag), $past(memData)})
    else $error("right rotate via carry wrong");
  sub_carry_a: assert property (take && opCode == RSSD_OP_SUBTRACT_WITH_BORROW |=>
    carryFlag == $past(noBorrow) && zeroFlag == (workReg == 8'h00)) else $error("sub flags");
  fill_ones_a: assert property (take && opCode == RSSD_OP_FILL_ONES |=>
    memWrite && memWriteData == 8'hff && $stable({carryFlag, zeroFlag})) else $error("fill");
  bit_set_a: assert property (take && opCode == RSSD_OP_SET_BIT |=>
    memWrite && memWriteData == $past(setByte)) else $error("bit set wrong");
  skip_result_a: assert property (skipNext |-> dummyCycle && !opReady &&
    (memWrite ? memWriteData == 8'h00 : workReg == 8'h00)) else $error("skip without zero");
  dummy_once_a: assert property (dummyCycle |=> opReady && !dummyCycle)
    else $error("dummy cycle length");
  dec_wrap_a: assert property (take && opCode == RSSD_OP_DECREMENT_SKIP_ZERO_TO_WORK
    && memData == 8'h00 |=> workReg == 8'hff && !skipNext) else $error("decrement wrap");
  cover property (skipNext && memWrite);
  cover property (take && opCode == RSSD_OP_SUBTRACT_WITH_BORROW && !noBorrow);
  cover property (opValid && !opReady);
endmodule : rssd_datapath_monitor
bind rssd_datapath rssd_datapath_monitor rssd_datapath_monitor_i (.clk, .srst, .opValid,
  .opCode, .memData, .bitSel, .opReady, .workReg, .carryFlag, .signedWrapFlag,
  .halfBorrowFlag, .zeroFlag, .memWrite, .memWriteData, .skipNext, .dummyCycle);

// [verif/rssd_memory_model.sv]
// Data memory byte that feeds the operand and takes write-backs
`timescale 1ns/1ns
module rssd_memory_model (
  input  wire logic       clk,
  input  wire logic       seedLoad,
  input  wire logic [7:0] seedData,
  input  wire logic       memWrite,
  input  wire logic [7:0] memWriteData,
  output logic      [7:0] memData
);
  logic [7:0] memByte_q;
  // Write-back lands at the edge after the pulse, like a real RAM
  always_ff @(posedge clk) begin
    if (seedLoad) memByte_q <= seedData;
    else if (memWrite) memByte_q <= memWriteData;
  end
  assign memData = memByte_q;
endmodule : rssd_memory_model

// [verif/rotate_subtract_skip_datapath_test.sv]
// Self-checking testbench for the datapath
`timescale 1ns/1ns
module rotate_subtract_skip_datapath_test;
  import rssd_pkg::*;
  logic clk = 1'b0, srst = 1'b1, opValid = 1'b0, seedLoad = 1'b0;
  rssd_op_t opCode = RSSD_OP_NONE;
  logic [7:0] seedData = 8'h00, memData, workReg, memWriteData;
  logic [2:0] bitSel = 3'h0;
  logic opReady, carryFlag, signedWrapFlag, halfBorrowFlag, zeroFlag;
  logic memWrite, skipNext, dummyCycle;
  int failures = 0, compares = 0;
  always #2 clk = ~clk;
  rssd_datapath rssd_datapath_i (.clk, .srst, .opValid, .opCode, .memData, .bitSel,
    .opReady, .workReg, .carryFlag, .signedWrapFlag, .halfBorrowFlag, .zeroFlag,
    .memWrite, .memWriteData, .skipNext, .dummyCycle);
  rssd_memory_model rssd_memory_model_i (.clk, .seedLoad, .seedData, .memWrite,
    .memWriteData, .memData);
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic run(input rssd_op_t op, input logic [7:0] m, input logic [2:0] b = 3'h0);
    @(posedge clk);
    seedLoad <= 1'b1;
    seedData <= m;
    @(posedge clk);
    seedLoad <= 1'b0;
    opValid <= 1'b1;
    opCode <= op;
    bitSel <= b;
    @(posedge clk);
    opValid <= 1'b0;
    #1;
  endtask : run
  task automatic s_rotates;
    run(RSSD_OP_ROTATE_LEFT_VIA_CARRY, 8'h81);
    chk(memWrite === 1'b1 && {carryFlag, memWriteData} === 9'h102, "rlc");
    run(RSSD_OP_ROTATE_RIGHT_PLAIN, 8'h02);
    chk(memWrite === 1'b1 && {carryFlag, memWriteData} === 9'h101, "rr");
    run(RSSD_OP_ROTATE_RIGHT_PLAIN_TO_WORK, 8'h02);
    chk(memWrite === 1'b0 && {carryFlag, workReg} === 9'h101, "rr work");
    run(RSSD_OP_ROTATE_LEFT_VIA_CARRY_TO_WORK, 8'h40);
    chk(memWrite === 1'b0 && {carryFlag, workReg} === 9'h081, "rlc work");
    run(RSSD_OP_ROTATE_RIGHT_VIA_CARRY, 8'h01);
    chk(memWrite === 1'b1 && {carryFlag, memWriteData} === 9'h100, "rrc");
    run(RSSD_OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK, 8'h02);
    chk(memWrite === 1'b0 && {carryFlag, workReg} === 9'h081, "rrc work");
  endtask : s_rotates
  task automatic s_subtract;
    // 81 - 01 - 1 = 7f: no borrow, but the signed result leaves the byte range
    run(RSSD_OP_SUBTRACT_WITH_BORROW, 8'h01);
    chk({workReg, carryFlag, signedWrapFlag, halfBorrowFlag, zeroFlag} === 12'h7fc,
      "sbc");
    run(RSSD_OP_SUBTRACT_WITH_BORROW_TO_MEMORY, 8'h7f);
    chk({memWriteData, carryFlag, signedWrapFlag, halfBorrowFlag, zeroFlag} === 12'h00b,
      "subtract_with_borrow_to_memory");
    chk(memWrite === 1'b1 && workReg === 8'h7f, "subtract_with_borrow_to_memory work kept");
    run(RSSD_OP_SUBTRACT_WITH_BORROW, 8'h80);
    chk({workReg, carryFlag, signedWrapFlag, halfBorrowFlag, zeroFlag} === 12'hff6,
      "borrow");
  endtask : s_subtract
  task automatic s_skip;
    @(posedge clk);
    seedLoad <= 1'b1;
    seedData <= 8'h01;
    @(posedge clk);
    seedLoad <= 1'b0;
    opValid <= 1'b1;
    opCode <= RSSD_OP_DECREMENT_SKIP_ZERO;
    @(posedge clk);
    opCode <= RSSD_OP_FILL_ONES;
    #1 chk({memWrite, memWriteData, skipNext, dummyCycle, opReady} === 12'h806, "sdz");
    @(posedge clk);
    opValid <= 1'b0;
    #1 chk({memWrite, skipNext, dummyCycle, opReady} === 4'h1, "refused");
    run(RSSD_OP_DECREMENT_SKIP_ZERO, 8'h00);
    chk({memWrite, memWriteData, skipNext} === 10'h3fe, "sdz wrap");
    run(RSSD_OP_DECREMENT_SKIP_ZERO_TO_WORK, 8'h00);
    chk({memWrite, workReg, skipNext} === 10'h1fe, "decrement_skip_zero_to_work wrap");
    run(RSSD_OP_DECREMENT_SKIP_ZERO_TO_WORK, 8'h01);
    chk({memWrite, workReg, skipNext, dummyCycle} === 11'h003, "decrement_skip_zero_to_work");
  endtask : s_skip
  task automatic s_fill_set;
    run(RSSD_OP_FILL_ONES, 8'h12);
    chk({memWriteData, carryFlag, signedWrapFlag, halfBorrowFlag, zeroFlag} === 12'hff6,
      "fill");
    for (int i = 0; i < 8; i++) begin
      run(RSSD_OP_SET_BIT, 8'h5a, 3'(i));
      chk(memWriteData === (8'h5a | (8'h01 << i)), "set bit");
    end
  endtask : s_fill_set
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1 chk({opReady, workReg, carryFlag, memWrite, skipNext} === 12'h800, "reset");
    s_rotates();
    s_subtract();
    s_skip();
    s_fill_set();
    finish_test();
  end
endmodule : rotate_subtract_skip_datapath_test
